// ---- hdl/slcd_pkg.sv ----
// constants, field layout and state encoding of the segment lcd driver
// assumes one 50 MHz system clock and sub clock ticks arriving as enable pulses
//
// Operation
// - duty bit picks four or six commons
// - display memory is scanned continuously
// - display memory at 00h-1fh, sector 4
// - memory bit one lights, zero blanks
// - bits without a common read zero
// - lcd clock is sub clock divided by eight
// - sub clock from oscillator or crystal
// - control bit 7 picks type a or b
// - control bits 2:1 pick bias current
// - enable works only outside sleep
// - unused commons released to pin logic
// - power bit picks pin or pump
// - power bits 2:0 set pump level
// - unimplemented bits read zero, reset clears
// - only resistor ladder one third bias
// - off or sleep drives low, reset floats

package slcd_pkg;

    // bus decode of the control registers (sector and offsets)
    localparam logic [7:0] REG_SECTOR = 8'h00;
    localparam logic [7:0] CTRL_ADDR = 8'h40;
    localparam logic [7:0] PWR_ADDR = 8'h41;

    // display memory window
    localparam logic [7:0] MEM_SECTOR = 8'h04;
    localparam logic [7:0] MEM_LAST = 8'h1f;
    localparam int MEM_WORDS = 32;
    localparam int MEM_BITS = 6;

    // lcd_control field layout
    localparam int CTRL_TYPE_BIT = 7;
    localparam int CTRL_BIAS_HI = 2;
    localparam int CTRL_BIAS_LO = 1;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [7:0] CTRL_MASK = 8'h87;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // lcd_duty_power_control field layout
    localparam int PWR_DUTY_BIT = 4;
    localparam int PWR_SRC_BIT = 3;
    localparam int PWR_PUMP_HI = 2;
    localparam logic [7:0] PWR_MASK = 8'h1f;
    localparam logic [7:0] PWR_RESET = 8'h00;

    // storage masks per duty
    localparam logic [5:0] MASK_4COM = 6'h0f;
    localparam logic [5:0] MASK_6COM = 6'h3f;

    // lcd clock divider: sub clock / 8
    localparam logic [2:0] DIV_LAST = 3'h7;

    // pin counts
    localparam int NUM_COM = 6;
    localparam int NUM_SEG = 32;
    localparam logic [2:0] COMS_4 = 3'h4;
    localparam logic [2:0] COMS_6 = 3'h6;
    localparam logic [5:0] SEGS_4COM = 6'h20;
    localparam logic [5:0] SEGS_6COM = 6'h1e;

    // drive level codes of the one third ladder
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_VC = 2'h1;
    localparam logic [1:0] LVL_VB = 2'h2;
    localparam logic [1:0] LVL_VA = 2'h3;

    typedef enum logic [1:0] {
        SLCD_OFF = 2'b01,
        SLCD_SCAN = 2'b10
    } slcd_state_t;

endpackage : slcd_pkg

// ---- hdl/slcd_driver.sv ----
// segment lcd driver: display memory, two control registers, scan and drive levels
// assumes cpu data memory port, sleep flag and sub clock ticks are synchronous to clk_sys_i
`timescale 1ns/100ps
`default_nettype none

module slcd_driver (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic sleep_i,
    input wire logic internal_slow_oscillator_tick_i,
    input wire logic external_slow_crystal_tick_i,
    input wire logic sub_clock_source_select_i,
    input wire logic cpu_wr_i,
    input wire logic [7:0] cpu_sector_i,
    input wire logic [7:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    output logic [11:0] com_lvl_o,
    output logic [5:0] com_oe_o,
    output logic [5:0] com_pin_free_o,
    output logic [63:0] seg_lvl_o,
    output logic [31:0] seg_oe_o,
    output logic [1:0] bias_current_select_o,
    output logic pump_en_o,
    output logic [2:0] pump_voltage_select_o
);

    // storage mask for the selected duty
    function automatic logic [5:0] duty_mask(input logic six);
        duty_mask = six ? slcd_pkg::MASK_6COM : slcd_pkg::MASK_4COM;
    endfunction : duty_mask

    // one third ladder level of a common, polarity 0 or 1
    function automatic logic [1:0] com_level(input logic sel, input logic pol);
        if (sel) begin
            com_level = pol ? slcd_pkg::LVL_VSS : slcd_pkg::LVL_VA;
        end else begin
            com_level = pol ? slcd_pkg::LVL_VB : slcd_pkg::LVL_VC;
        end
    endfunction : com_level

    // segment level: lit pixel sees full swing, dark pixel one third
    function automatic logic [1:0] seg_level(input logic lit, input logic pol);
        if (lit) begin
            seg_level = pol ? slcd_pkg::LVL_VA : slcd_pkg::LVL_VSS;
        end else begin
            seg_level = pol ? slcd_pkg::LVL_VC : slcd_pkg::LVL_VB;
        end
    endfunction : seg_level

    logic [7:0] ctrl; // lcd_control
    logic [7:0] pwr; // lcd_duty_power_control
    logic [7:0] next_ctrl;
    logic [7:0] next_pwr;
    logic [5:0] mem [0:slcd_pkg::MEM_WORDS-1]; // display memory, no reset
    logic [7:0] next_rdata;
    slcd_pkg::slcd_state_t state;
    slcd_pkg::slcd_state_t next_state;
    logic [2:0] div_cnt; // sub clock divider
    logic [2:0] next_div_cnt;
    logic [2:0] com_idx; // common slot now driven
    logic [2:0] next_com_idx;
    logic half; // type a: second half of slot
    logic next_half;
    logic frame_pol; // type b: frame polarity
    logic next_frame_pol;
    logic [11:0] next_com_lvl;
    logic [5:0] next_com_oe;
    logic [63:0] next_seg_lvl;
    logic [31:0] next_seg_oe;
    logic next_pump_en;

    // decoded controls
    logic duty6;
    logic type_b;
    logic active;
    logic sub_tick;
    logic lcd_tick;
    logic mem_hit;
    logic ctrl_hit;
    logic pwr_hit;
    logic pol;
    logic [2:0] com_cnt;
    logic [5:0] seg_cnt;

    assign duty6 = pwr[slcd_pkg::PWR_DUTY_BIT];
    assign type_b = ctrl[slcd_pkg::CTRL_TYPE_BIT];
    assign active = (state == slcd_pkg::SLCD_SCAN);
    assign com_cnt = duty6 ? slcd_pkg::COMS_6 : slcd_pkg::COMS_4;
    assign seg_cnt = duty6 ? slcd_pkg::SEGS_6COM : slcd_pkg::SEGS_4COM;
    // sub clock source pick
    assign sub_tick = sub_clock_source_select_i ? external_slow_crystal_tick_i
                                                : internal_slow_oscillator_tick_i;
    // lcd clock is every eighth sub tick
    assign lcd_tick = active && sub_tick && (div_cnt == slcd_pkg::DIV_LAST);
    // software must set sector 04h first; only that sector reaches memory
    assign mem_hit = (cpu_sector_i == slcd_pkg::MEM_SECTOR)
                     && (cpu_addr_i <= slcd_pkg::MEM_LAST);
    assign ctrl_hit = (cpu_sector_i == slcd_pkg::REG_SECTOR)
                      && (cpu_addr_i == slcd_pkg::CTRL_ADDR);
    assign pwr_hit = (cpu_sector_i == slcd_pkg::REG_SECTOR)
                     && (cpu_addr_i == slcd_pkg::PWR_ADDR);
    assign pol = type_b ? frame_pol : half;
    // commons beyond the duty go back to the pin mux
    assign com_pin_free_o = duty6 ? 6'h00 : 6'h30;

    // register writes and read data; reserved bits never stored
    always_comb begin
        next_ctrl = ctrl;
        next_pwr = pwr;
        next_rdata = 8'h00;
        if (cpu_wr_i && ctrl_hit) begin
            next_ctrl = cpu_wdata_i & slcd_pkg::CTRL_MASK;
        end
        if (cpu_wr_i && pwr_hit) begin
            next_pwr = cpu_wdata_i & slcd_pkg::PWR_MASK;
        end
        if (mem_hit) begin
            // bits with no common read zero
            next_rdata = {2'h0, mem[cpu_addr_i[4:0]] & duty_mask(duty6)};
        end else if (ctrl_hit) begin
            next_rdata = ctrl;
        end else if (pwr_hit) begin
            next_rdata = pwr;
        end
    end

    // control registers clear at reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= slcd_pkg::CTRL_RESET;
            pwr <= slcd_pkg::PWR_RESET;
            cpu_rdata_o <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            pwr <= next_pwr;
            cpu_rdata_o <= next_rdata;
        end
    end

    // display memory; unbacked bits are stored as zero
    always_ff @(posedge clk_sys_i) begin
        if (cpu_wr_i && mem_hit) begin
            mem[cpu_addr_i[4:0]] <= cpu_wdata_i[5:0] & duty_mask(duty6);
        end
    end

    // enable is honoured only while awake; sleep forces off
    always_comb begin
        next_state = state;
        case (state)
            slcd_pkg::SLCD_OFF: begin
                if (ctrl[slcd_pkg::CTRL_EN_BIT] && !sleep_i) begin
                    next_state = slcd_pkg::SLCD_SCAN;
                end
            end
            slcd_pkg::SLCD_SCAN: begin
                if (!ctrl[slcd_pkg::CTRL_EN_BIT] || sleep_i) begin
                    next_state = slcd_pkg::SLCD_OFF;
                end
            end
            default: begin
                next_state = slcd_pkg::SLCD_OFF;
            end
        endcase
    end

    // scan sequencer: divider, slot, half slot, frame polarity
    always_comb begin
        next_div_cnt = div_cnt;
        next_com_idx = com_idx;
        next_half = half;
        next_frame_pol = frame_pol;
        if (!active) begin
            // held in reset so every enable starts a fresh frame
            next_div_cnt = 3'h0;
            next_com_idx = 3'h0;
            next_half = 1'b0;
            next_frame_pol = 1'b0;
        end else begin
            if (sub_tick) begin
                next_div_cnt = div_cnt + 3'h1;
            end
            if (lcd_tick) begin
                // type a flips inside each slot, type b once per frame
                if (!type_b) begin
                    next_half = !half;
                end
                if (type_b || half) begin
                    if (com_idx >= com_cnt - 3'h1) begin
                        next_com_idx = 3'h0;
                        next_frame_pol = !frame_pol;
                    end else begin
                        next_com_idx = com_idx + 3'h1;
                    end
                end
            end
        end
    end

    // drive levels, fetched live from memory every cycle
    always_comb begin
        next_com_lvl = 12'h000;
        next_com_oe = 6'h00;
        next_seg_lvl = 64'h0;
        next_seg_oe = 32'h0;
        next_pump_en = active && pwr[slcd_pkg::PWR_SRC_BIT];
        for (int c = 0; c < slcd_pkg::NUM_COM; c++) begin
            next_com_oe[c] = (3'(c) < com_cnt);
            if (active) begin
                // only the one third ladder levels exist
                next_com_lvl[2*c +: 2] = com_level(com_idx == 3'(c), pol);
            end
        end
        for (int s = 0; s < slcd_pkg::NUM_SEG; s++) begin
            next_seg_oe[s] = (6'(s) < seg_cnt);
            if (active) begin
                next_seg_lvl[2*s +: 2] = seg_level(mem[s][com_idx], pol);
            end
        end
    end

    // outputs float (oe low) while the mcu reset is held
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= slcd_pkg::SLCD_OFF;
            div_cnt <= 3'h0;
            com_idx <= 3'h0;
            half <= 1'b0;
            frame_pol <= 1'b0;
            com_lvl_o <= 12'h000;
            com_oe_o <= 6'h00;
            seg_lvl_o <= 64'h0;
            seg_oe_o <= 32'h0;
            pump_en_o <= 1'b0;
            bias_current_select_o <= 2'h0;
            pump_voltage_select_o <= 3'h0;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            com_idx <= next_com_idx;
            half <= next_half;
            frame_pol <= next_frame_pol;
            com_lvl_o <= next_com_lvl;
            com_oe_o <= next_com_oe;
            seg_lvl_o <= next_seg_lvl;
            seg_oe_o <= next_seg_oe;
            pump_en_o <= next_pump_en;
            // raw codes to the analog bias and pump trims
            bias_current_select_o <= ctrl[slcd_pkg::CTRL_BIAS_HI:slcd_pkg::CTRL_BIAS_LO];
            pump_voltage_select_o <= pwr[slcd_pkg::PWR_PUMP_HI:0];
        end
    end

    // checks
    chk_off_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !active |=> (com_lvl_o == 12'h000) && (seg_lvl_o == 64'h0))
        else $error("drive not low while lcd held off");

    chk_sleep_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        sleep_i |=> (state == slcd_pkg::SLCD_OFF))
        else $error("lcd still scanning in sleep");

    chk_com_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        1'b1 |=> (com_oe_o == {{2{$past(duty6)}}, 4'hf}))
        else $error("common enables do not match duty");

    chk_div_gap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        lcd_tick |=> (!lcd_tick) [*7])
        else $error("lcd clock faster than sub clock over eight");

    chk_src_pick: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        lcd_tick |-> (sub_clock_source_select_i ? external_slow_crystal_tick_i
                                                : internal_slow_oscillator_tick_i))
        else $error("lcd clock from unselected source");

    chk_mem_mask: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (mem_hit && !duty6) |=> (cpu_rdata_o[7:4] == 4'h0))
        else $error("unbacked display bits read nonzero");

    chk_ctrl_rsvd: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctrl_hit |=> (cpu_rdata_o[6:3] == 4'h0))
        else $error("reserved control bits read nonzero");

    chk_pump_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !pwr[slcd_pkg::PWR_SRC_BIT] |=> !pump_en_o)
        else $error("pump on while panel powered from pin");

    chk_scan_step: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (lcd_tick && type_b && !sleep_i && ctrl[slcd_pkg::CTRL_EN_BIT])
        |=> (com_idx != $past(com_idx)))
        else $error("type b slot did not advance");

    chk_pwr_rsvd: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        pwr_hit |=> (cpu_rdata_o[7:5] == 3'h0))
        else $error("reserved power bits read nonzero");

    chk_seg_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        duty6 |=> (seg_oe_o == 32'h3fffffff))
        else $error("segment enables do not match six common duty");

endmodule : slcd_driver
`default_nettype wire

// ---- testbench/slcd_panel_model.sv ----
// panel model: watches the drive levels, records lit pixels and the net dc per pixel
// assumes level codes 0..3 are equal steps of one third of the panel voltage
`timescale 1ns/100ps
`default_nettype none

module slcd_panel_model (
    input wire logic clk_sys_i,
    input wire logic clear_i,
    input wire logic [11:0] com_lvl_i,
    input wire logic [5:0] com_oe_i,
    input wire logic [63:0] seg_lvl_i,
    input wire logic [31:0] seg_oe_i,
    output logic [191:0] seen_o,
    output logic dc_zero_o
);
    int dc_sum [192]; // summed com minus seg voltage, pixel index com*32+seg
    int diff; // present voltage across one pixel in thirds
    logic all_zero; // no pixel carries a dc offset

    // full swing across a pixel means lit; a floating or undriven pin never lights
    always @(posedge clk_sys_i) begin
        all_zero = 1'b1;
        for (int p = 0; p < 192; p++) begin
            diff = int'(com_lvl_i[2*(p/32) +: 2]) - int'(seg_lvl_i[2*(p%32) +: 2]);
            if (clear_i) begin
                seen_o[p] <= 1'b0;
                dc_sum[p] = 0;
            end else if (com_oe_i[p/32] && seg_oe_i[p%32]) begin
                if (diff == 3 || diff == -3) seen_o[p] <= 1'b1;
                dc_sum[p] = dc_sum[p] + diff;
            end
            if (dc_sum[p] != 0) all_zero = 1'b0;
        end
        dc_zero_o <= all_zero;
    end
endmodule : slcd_panel_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench of the segment lcd driver with a panel model on its pins
// assumes sub clock ticks every fourth system clock, so one lcd tick is 32 clocks
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, sleep_i = 1'b0; // clock, reset, sleep
    logic osc_tick = 1'b0, xtal_tick = 1'b0, src_sel = 1'b0; // sub clock ticks
    logic osc_run = 1'b1, xtal_run = 1'b0, clear = 1'b1; // tick gates, model clear
    logic cpu_wr_i = 1'b0;
    logic [7:0] cpu_sector_i = 8'h00, cpu_addr_i = 8'h00, cpu_wdata_i = 8'h00;
    logic [7:0] cpu_rdata_o;
    logic [11:0] com_lvl_o;
    logic [5:0] com_oe_o, com_pin_free_o;
    logic [63:0] seg_lvl_o;
    logic [31:0] seg_oe_o;
    logic [1:0] bias_current_select_o;
    logic pump_en_o, dc_zero;
    logic [2:0] pump_voltage_select_o;
    logic [191:0] seen;
    int mismatches = 0, check_count = 0, cyc = 0, n = 0;

    slcd_driver dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sleep_i(sleep_i),
        .internal_slow_oscillator_tick_i(osc_tick), .external_slow_crystal_tick_i(xtal_tick),
        .sub_clock_source_select_i(src_sel), .cpu_wr_i(cpu_wr_i),
        .cpu_sector_i(cpu_sector_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_rdata_o(cpu_rdata_o), .com_lvl_o(com_lvl_o), .com_oe_o(com_oe_o),
        .com_pin_free_o(com_pin_free_o), .seg_lvl_o(seg_lvl_o), .seg_oe_o(seg_oe_o),
        .bias_current_select_o(bias_current_select_o), .pump_en_o(pump_en_o),
        .pump_voltage_select_o(pump_voltage_select_o));

    slcd_panel_model panel (.clk_sys_i(clk_sys_i), .clear_i(clear), .com_lvl_i(com_lvl_o),
        .com_oe_i(com_oe_o), .seg_lvl_i(seg_lvl_o), .seg_oe_i(seg_oe_o), .seen_o(seen),
        .dc_zero_o(dc_zero));

    // 50 MHz system clock
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // sub clock ticks, one clock wide; the two sources are offset so they never coincide
    initial begin
        forever @(negedge clk_sys_i) begin
            cyc++;
            osc_tick <= osc_run && (cyc % 4 == 0);
            xtal_tick <= xtal_run && (cyc % 4 == 2);
        end
    end

    // one byte write, strobe held across exactly one rising edge
    task automatic wr(input logic [7:0] sec, input logic [7:0] adr, input logic [7:0] dat);
        @(negedge clk_sys_i);
        cpu_wr_i = 1'b1;
        cpu_sector_i = sec;
        cpu_addr_i = adr;
        cpu_wdata_i = dat;
        @(negedge clk_sys_i);
        cpu_wr_i = 1'b0;
    endtask : wr

    // read data is registered, so it is taken one clock after the address
    task automatic rd(input logic [7:0] sec, input logic [7:0] adr, input logic [7:0] exp);
        @(negedge clk_sys_i);
        cpu_sector_i = sec;
        cpu_addr_i = adr;
        @(negedge clk_sys_i);
        check_reg(cpu_rdata_o, exp);
    endtask : rd

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_pins(input logic [191:0] got, input logic [191:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_pins

    // counts clocks until the common levels move; gives up at 200
    task automatic wait_change(output int cnt);
        logic [11:0] last;
        last = com_lvl_o;
        cnt = 0;
        while (com_lvl_o === last && cnt < 200) begin
            @(negedge clk_sys_i);
            cnt++;
        end
    endtask : wait_change

    // load a pattern, let the scan settle, then watch one full waveform period
    task automatic scan_check(input int ncom, input logic [7:0] flip);
        logic [191:0] exp;
        logic [7:0] d;
        exp = '0;
        for (int s = 0; s < 32; s++) begin
            d = 8'(s * 37) ^ flip;
            wr(slcd_pkg::MEM_SECTOR, 8'(s), d);
            for (int c = 0; c < ncom; c++) exp[c*32+s] = d[c] && (s < 36 - ncom);
        end
        repeat (ncom * 128) @(negedge clk_sys_i);
        clear = 1'b1;
        @(negedge clk_sys_i);
        clear = 1'b0;
        repeat (ncom * 64) @(negedge clk_sys_i);
        check_pins(seen, exp);
        check_pins(192'(dc_zero), 192'h1);
    endtask : scan_check

    task automatic summarize();
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // a hung wait must not stall the run; the tests need well under 20000 clocks
    initial begin
        #1000000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (2) @(negedge clk_sys_i);
        check_pins(192'({com_oe_o, seg_oe_o}), 192'h0);
        nrst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        // fields are 6, 32 and 6 bits wide, so they do not sit on hex digit borders
        check_pins(192'({com_oe_o, seg_oe_o, com_pin_free_o}), 192'h3fffffffff0);
        rd(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'h00);
        rd(slcd_pkg::REG_SECTOR, slcd_pkg::PWR_ADDR, 8'h00);
        for (int v = 0; v < 8; v++) begin
            wr(slcd_pkg::REG_SECTOR, slcd_pkg::PWR_ADDR, 8'(v));
            rd(slcd_pkg::REG_SECTOR, slcd_pkg::PWR_ADDR, 8'(v));
            check_reg(8'(pump_voltage_select_o), 8'(v));
        end
        for (int b = 0; b < 4; b++) begin
            wr(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'(b * 2));
            rd(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'(b * 2));
            check_reg(8'(bias_current_select_o), 8'(b));
        end
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'hfe);
        rd(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'h86);
        wr(slcd_pkg::MEM_SECTOR, 8'h00, 8'hff);
        rd(slcd_pkg::MEM_SECTOR, 8'h00, 8'h0f);
        rd(slcd_pkg::MEM_SECTOR, 8'h20, 8'h00);
        rd(8'h05, 8'h00, 8'h00);
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::PWR_ADDR, 8'hff);
        rd(slcd_pkg::REG_SECTOR, slcd_pkg::PWR_ADDR, 8'h1f);
        // six commons driven, segments 30 and 31 released, no common freed
        check_pins(192'({com_oe_o, seg_oe_o, com_pin_free_o}), 192'hfcfffffffc0);
        rd(slcd_pkg::MEM_SECTOR, 8'h00, 8'h0f);
        wr(slcd_pkg::MEM_SECTOR, 8'h00, 8'hff);
        rd(slcd_pkg::MEM_SECTOR, 8'h00, 8'h3f);
        // four commons, type a, pump supply, oscillator ticks
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::PWR_ADDR, 8'h08);
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'h01);
        repeat (3) @(negedge clk_sys_i);
        check_reg(8'(pump_en_o), 8'h01);
        scan_check(4, 8'h00);
        scan_check(4, 8'hff);
        wait_change(n);
        wait_change(n);
        check_reg(8'(n), 8'h20);
        src_sel = 1'b1;
        wait_change(n);
        wait_change(n);
        check_reg(8'(n), 8'hc8);
        xtal_run = 1'b1;
        wait_change(n);
        wait_change(n);
        check_reg(8'(n), 8'h20);
        sleep_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        check_pins(192'({com_lvl_o, seg_lvl_o, pump_en_o}), 192'h0);
        check_reg(8'(com_oe_o), 8'h0f);
        sleep_i = 1'b0;
        // six commons, type b, panel pin supply so the pump stays off
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::PWR_ADDR, 8'h10);
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'h81);
        repeat (3) @(negedge clk_sys_i);
        check_reg(8'(pump_en_o), 8'h00);
        scan_check(6, 8'h5a);
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'h80);
        repeat (3) @(negedge clk_sys_i);
        check_pins(192'({com_lvl_o, seg_lvl_o}), 192'h0);
        wr(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'h81);
        nrst_i = 1'b0;
        @(negedge clk_sys_i);
        check_pins(192'({com_oe_o, seg_oe_o}), 192'h0);
        nrst_i = 1'b1;
        rd(slcd_pkg::REG_SECTOR, slcd_pkg::CTRL_ADDR, 8'h00);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
